/* hdl/operand_sizing_ea_decode.sv */
// Effective-address decode, register file sizing and postincrement update.
`timescale 1ns/1ns
`include "ea_decode_params.svh"
module operand_sizing_ea_decode (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic supervisor,
    input wire ea_decode_pkg::request_type req,
    output ea_decode_pkg::result_type res_q,
    output logic [31:0] mem_word_addr_q,
    output logic [31:0] mem_second_addr_q
);
    import ea_decode_pkg::*;

    // ************************************************************
    // Register file
    // ************************************************************
    logic [31:0] data_reg_q [0:7]; // [RL3]
    logic [31:0] addr_reg_q [0:6];
    logic [31:0] supervisor_stack_pointer_q;
    logic [31:0] user_stack_pointer_q;

    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    assign ea_mode = req.op_word[`EA_MODE_HI:`EA_MODE_LO]; // [RL13] [RL22]
    assign ea_reg = req.op_word[`EA_REG_HI:`EA_REG_LO]; // [RL22]

    // Reading A7 always returns the active pointer; the other is hidden.
    function automatic logic [31:0] addr_read(input logic [2:0] n, input logic sup);
        logic [31:0] v;
        v = `REG_RESET;
        if (n == `SP_INDEX) begin
            v = sup ? supervisor_stack_pointer_q : user_stack_pointer_q; // [RL21]
        end else begin
            v = addr_reg_q[n];
        end
        return v;
    endfunction

    logic [31:0] ea_addr;
    logic [31:0] ea_data;
    logic [31:0] inc_amount;
    logic [31:0] sized_src;
    logic [31:0] word_ext;
    logic mode_ok;

    always_comb begin
        ea_addr = addr_read(ea_reg, supervisor); // [RL18]
        ea_data = data_reg_q[ea_reg];
        mode_ok = (ea_mode == `MODE_DATA_DIRECT) || (ea_mode == `MODE_ADDR_DIRECT) ||
                  (ea_mode == `MODE_INDIRECT) || (ea_mode == `MODE_POSTINC);
        case (req.size)
            SIZE_BYTE: begin
                // Stack pointer stays word aligned on byte pops.
                inc_amount = (ea_reg == `SP_INDEX) ? `INC_WORD : `INC_BYTE; // [RL20]
            end
            SIZE_WORD: begin
                inc_amount = `INC_WORD; // [RL19]
            end
            default: begin
                inc_amount = `INC_LONG; // [RL19]
            end
        endcase
        // Source operand sized to its low portion; an address register gives its whole long except for words.
        sized_src = `REG_RESET;
        case (ea_mode)
            `MODE_DATA_DIRECT: begin
                case (req.size)
                    SIZE_BYTE: sized_src = {24'h000000, ea_data[7:0]}; // [RL1] [RL16]
                    SIZE_WORD: sized_src = {16'h0000, ea_data[15:0]}; // [RL1]
                    default: sized_src = ea_data; // [RL1]
                endcase
            end
            `MODE_ADDR_DIRECT: begin
                if (req.size == SIZE_WORD) begin
                    sized_src = {16'h0000, ea_addr[15:0]}; // [RL4] [RL17]
                end else begin
                    sized_src = ea_addr; // [RL4]
                end
            end
            default: begin
                sized_src = `REG_RESET;
            end
        endcase
        word_ext = {{16{req.wdata[15]}}, req.wdata[15:0]}; // [RL6]
    end

    // ************************************************************
    // Register write decode and data register writes
    // ************************************************************
    // The opcode picks the register kind; the number comes from a field.
    logic dwr;
    logic [2:0] dwr_n;
    logic awr;
    logic [2:0] awr_n;
    logic [31:0] awr_v;
    logic postinc;

    always_comb begin
        postinc = req.valid && (ea_mode == `MODE_POSTINC) && (req.size != SIZE_NONE);
        dwr = 1'b0;
        dwr_n = ea_reg;
        awr = 1'b0;
        awr_n = ea_reg;
        awr_v = req.wdata;
        if (req.valid && req.ea_is_dest) begin
            dwr = (ea_mode == `MODE_DATA_DIRECT); // [RL16]
            awr = (ea_mode == `MODE_ADDR_DIRECT); // [RL17]
        end else if (req.valid && !postinc) begin
            dwr = !req.dest_is_addr; // [RL15]
            awr = req.dest_is_addr; // [RL15]
            dwr_n = req.dest_reg;
            awr_n = req.dest_reg;
        end
        if (req.size == SIZE_WORD) begin
            awr_v = word_ext; // [RL6]
        end
        if (postinc) begin
            awr = 1'b1;
            awr_n = ea_reg;
            awr_v = ea_addr + inc_amount; // [RL19]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) begin
                data_reg_q[i] <= `REG_RESET;
            end
        end else if (clk_en && dwr && req.size != SIZE_NONE) begin
            // Upper bits are held for narrow writes.
            case (req.size)
                SIZE_BYTE: data_reg_q[dwr_n][7:0] <= req.wdata[7:0]; // [RL2]
                SIZE_WORD: data_reg_q[dwr_n][15:0] <= req.wdata[15:0]; // [RL2]
                default: data_reg_q[dwr_n] <= req.wdata; // [RL1]
            endcase
        end
    end

    // ************************************************************
    // Address register and stack pointer writes
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            for (int i = 0; i < 7; i++) begin
                addr_reg_q[i] <= `REG_RESET;
            end
            supervisor_stack_pointer_q <= `REG_RESET;
            user_stack_pointer_q <= `REG_RESET;
        end else if (clk_en && awr) begin
            if (awr_n == `SP_INDEX) begin
                if (supervisor) begin
                    supervisor_stack_pointer_q <= awr_v; // [RL21] [RL5]
                end else begin
                    user_stack_pointer_q <= awr_v; // [RL21] [RL5]
                end
            end else begin
                addr_reg_q[awr_n] <= awr_v; // [RL5]
            end
        end
    end

    // ************************************************************
    // Decode result
    // ************************************************************
    logic [2:0] total_words;
    always_comb begin
        // Opword plus immediate, source and destination extensions.
        total_words = 3'h1 + req.imm_words + req.src_ext_words + req.dst_ext_words; // [RL10] [RL14]
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            res_q <= '0;
            mem_word_addr_q <= `REG_RESET;
            mem_second_addr_q <= `REG_RESET;
        end else if (clk_en) begin
            res_q.valid <= req.valid;
            res_q.illegal <= req.valid && (!mode_ok || total_words > `MAX_INSN_WORDS ||
                             req.size == SIZE_NONE); // [RL10]
            res_q.operand <= sized_src;
            res_q.insn_words <= total_words; // [RL10]
            // Index of the first extension word after the opword; immediate
            // comes first, then source, then destination.
            res_q.first_ext <= (req.imm_words != 3'h0) ? 2'h0 :
                               (req.src_ext_words != 3'h0) ? 2'h1 : 2'h2; // [RL11]
            res_q.addr_valid <= req.valid && (ea_mode == `MODE_INDIRECT ||
                                ea_mode == `MODE_POSTINC); // [RL18] [RL19]
            res_q.address <= ea_addr; // [RL18] [RL19]
            // Writes are never program space; only jumps through indirect are.
            res_q.program_space <= req.valid && !req.ea_is_dest && req.is_jump &&
                                   (ea_mode == `MODE_INDIRECT); // [RL12] [RL18]
            // Odd address is flagged for words and longs; bytes may be odd.
            res_q.misaligned <= req.valid && (ea_mode == `MODE_INDIRECT ||
                                ea_mode == `MODE_POSTINC) && ea_addr[0] &&
                                req.size != SIZE_BYTE; // [RL8]
            // High-order word at n, low-order word at n + 2; the high byte of
            // each word lives at its even address.
            mem_word_addr_q <= {ea_addr[31:1], 1'b0}; // [RL7] [RL9]
            mem_second_addr_q <= {ea_addr[31:1], 1'b0} + `INC_WORD; // [RL9]
        end
    end
endmodule

/* hdl/ea_decode_params.svh */
// Constants for the operand sizing and effective-address front end.
// Contract
// RL1: Data registers 32 bits; byte/word/long low portions.
// RL2: Byte/word writes leave upper data bits unchanged.
// RL3: Bit zero least significant, bit 31 most.
// RL4: Address source uses low word or long.
// RL5: Address destination always written in full.
// RL6: Word operands sign-extended for address targets.
// RL7: High byte at even address, low at odd.
// RL8: Fetches and multibyte accesses only at even addresses.
// RL9: Long at n: high word n, low n+2.
// RL10: Instructions one to five words; opword sets length.
// RL11: Extensions ordered immediate, source, then destination.
// RL12: Writes data space; reads data except PC-relative.
// RL13: Effective address is mode and register fields.
// RL14: Extension words follow opword, part of instruction.
// RL15: Register field selects number; opcode selects kind.
// RL16: Data-register-direct uses numbered data register.
// RL17: Address-register-direct uses numbered address register.
// RL18: Indirect address is register; jumps make program refs.
// RL19: Postincrement adds one, two or four after access.
// RL20: Byte postincrement of stack pointer adds two.
// RL21: Register seven is supervisor or user stack pointer.
// RL22: Mode bits 5..3, register bits 2..0.
`ifndef EA_DECODE_PARAMS_SVH
`define EA_DECODE_PARAMS_SVH
`define EA_MODE_HI 5
`define EA_MODE_LO 3
`define EA_REG_HI 2
`define EA_REG_LO 0
`define REG_RESET 32'h0000_0000
`define SP_INDEX 3'h7
`define MAX_INSN_WORDS 3'h5
`define INC_BYTE 32'h0000_0001
`define INC_WORD 32'h0000_0002
`define INC_LONG 32'h0000_0004
`define MODE_DATA_DIRECT 3'h0
`define MODE_ADDR_DIRECT 3'h1
`define MODE_INDIRECT 3'h2
`define MODE_POSTINC 3'h3
`endif

/* hdl/ea_decode_pkg.sv */
// Types shared by the effective-address front end.
package ea_decode_pkg;
    typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG, SIZE_NONE} size_type;
    typedef struct packed {
        logic valid;
        logic [15:0] op_word;
        size_type size;
        logic ea_is_dest;
        logic dest_is_addr;
        logic [2:0] dest_reg;
        logic is_jump;
        logic [2:0] imm_words;
        logic [2:0] src_ext_words;
        logic [2:0] dst_ext_words;
        logic [31:0] wdata;
    } request_type;
    typedef struct packed {
        logic valid;
        logic illegal;
        logic [31:0] operand;
        logic [31:0] address;
        logic addr_valid;
        logic program_space;
        logic [2:0] insn_words;
        logic [1:0] first_ext;
        logic misaligned;
    } result_type;
endpackage

/* verif/ea_decode_props.sv */
// Concurrent checks on the ports of the effective-address front end.
`timescale 1ns/1ns
module ea_decode_props (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire ea_decode_pkg::request_type req,
    input wire ea_decode_pkg::result_type res_q,
    input wire logic [31:0] mem_word_addr_q,
    input wire logic [31:0] mem_second_addr_q
);
    import ea_decode_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_take;
        req.valid && clk_en;
    endsequence
    sequence s_mem_answer;
        s_take ##1 res_q.addr_valid;
    endsequence
    a_answer_next: assert property (s_take |=> res_q.valid) else $error("no answer");
    a_mode_addr: assert property (s_take |=>
        res_q.addr_valid == ($past(req.op_word[5:4]) == 2'h1)) else $error("addr_valid wrong");
    a_prog_space: assert property (s_take |=> res_q.program_space ==
        ($past(req.is_jump) && !$past(req.ea_is_dest) && $past(req.op_word[5:3]) == 3'h2))
        else $error("space wrong");
    a_insn_count: assert property (s_take |=> res_q.insn_words ==
        $past(req.imm_words) + $past(req.src_ext_words) + $past(req.dst_ext_words) + 3'h1)
        else $error("length wrong");
    a_ext_order: assert property (s_take |=> res_q.first_ext ==
        ($past(req.imm_words) != 3'h0 ? 2'h0 : $past(req.src_ext_words) != 3'h0 ? 2'h1 : 2'h2))
        else $error("extension order wrong");
    a_illegal_code: assert property (s_take |=> res_q.illegal == ($past(req.op_word[5]) ||
        $past(req.size) == SIZE_NONE || res_q.insn_words > 3'h5)) else $error("illegal wrong");
    a_even_fetch: assert property (!mem_word_addr_q[0]) else $error("odd word address");
    a_long_second: assert property (res_q.valid |->
        mem_second_addr_q == mem_word_addr_q + 32'h2) else $error("second address wrong");
    a_misalign_flag: assert property (s_mem_answer |-> res_q.misaligned ==
        (res_q.address[0] && $past(req.size) != SIZE_BYTE)) else $error("misaligned wrong");
    a_word_from_reg: assert property (s_mem_answer |->
        mem_word_addr_q == {res_q.address[31:1], 1'b0}) else $error("word address wrong");
endmodule
bind operand_sizing_ea_decode ea_decode_props i_props (.core_clk(core_clk), .rstn(rstn),
    .clk_en(clk_en), .req(req), .res_q(res_q), .mem_word_addr_q(mem_word_addr_q),
    .mem_second_addr_q(mem_second_addr_q));

/* verif/ea_mem_model.sv */
// Behavioural program and data memory answering the front end's word addresses.
`timescale 1ns/1ns
module ea_mem_model (
    input wire logic [31:0] word_addr,
    input wire logic [31:0] second_addr,
    output logic [15:0] hi_word,
    output logic [15:0] lo_word
);
    logic [7:0] bytes [0:255];
    initial begin
        for (int i = 0; i < 256; i++) begin
            bytes[i] = 8'(i) ^ 8'h5A;
        end
    end
    // Only word boundaries are answered, so an odd request is served from the even address below it.
    assign hi_word = {bytes[{word_addr[7:1], 1'b0}], bytes[{word_addr[7:1], 1'b1}]};
    assign lo_word = {bytes[{second_addr[7:1], 1'b0}], bytes[{second_addr[7:1], 1'b1}]};
endmodule

/* verif/operand_sizing_ea_decode_test.sv */
// Self-checking bench for the effective-address front end.
`timescale 1ns/1ns
module operand_sizing_ea_decode_test;
    import ea_decode_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic supervisor = 1'b0;
    logic clk_en = 1'b1;
    request_type req = '0;
    result_type res_q;
    logic [31:0] mem_word_addr_q;
    logic [31:0] mem_second_addr_q;
    logic [15:0] hi_word;
    logic [15:0] lo_word;
    int mismatches = 0;
    int n_checks = 0;
    always #50 core_clk = ~core_clk;
    operand_sizing_ea_decode i_dut (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
        .supervisor(supervisor), .req(req), .res_q(res_q), .mem_word_addr_q(mem_word_addr_q),
        .mem_second_addr_q(mem_second_addr_q));
    ea_mem_model i_mem (.word_addr(mem_word_addr_q), .second_addr(mem_second_addr_q),
        .hi_word(hi_word), .lo_word(lo_word));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic issue(input logic [5:0] ea, input size_type sz, input logic da,
            input logic [2:0] dr, input logic [31:0] wd, input logic jmp = 1'b0,
            input logic [8:0] ext = 9'h000);
        @(posedge core_clk);
        #1;
        req = '{valid: 1'b1, op_word: {10'h000, ea}, size: sz, ea_is_dest: 1'b0,
            dest_is_addr: da, dest_reg: dr, is_jump: jmp, imm_words: ext[8:6],
            src_ext_words: ext[5:3], dst_ext_words: ext[2:0], wdata: wd};
        @(posedge core_clk);
        #1;
        req.valid = 1'b0;
    endtask
    // Writes take D7 as the source and reads other than postincrement write D7, so D7 is kept as scratch.
    task automatic wr(input logic da, input logic [2:0] r, input size_type sz, input logic [31:0] v);
        issue(6'h07, sz, da, r, v);
    endtask
    task automatic rd(input logic [2:0] mode, input logic [2:0] r, input size_type sz);
        issue({mode, r}, sz, 1'b0, 3'h7, 32'h0);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic test_data_sizes();
        wr(1'b0, 3'h1, SIZE_LONG, 32'h1122_3344);
        wr(1'b0, 3'h1, SIZE_BYTE, 32'h5555_55AA);
        rd(3'h0, 3'h1, SIZE_LONG);
        check("d1 after byte", res_q.operand, 32'h1122_33AA);
        wr(1'b0, 3'h1, SIZE_WORD, 32'h6666_BEEF);
        rd(3'h0, 3'h1, SIZE_BYTE);
        check("d1 byte", res_q.operand, 32'h0000_00EF);
        rd(3'h0, 3'h1, SIZE_LONG);
        check("d1 after word", res_q.operand, 32'h1122_BEEF);
        // A request offered while the clock enable is low must leave no trace.
        clk_en = 1'b0;
        wr(1'b0, 3'h1, SIZE_LONG, 32'hDEAD_0000);
        clk_en = 1'b1;
        rd(3'h0, 3'h1, SIZE_LONG);
        check("d1 frozen", res_q.operand, 32'h1122_BEEF);
        wr(1'b0, 3'h2, SIZE_LONG, 32'h8000_0001);
        rd(3'h0, 3'h2, SIZE_LONG);
        check("d2 msb", res_q.operand[31], 1'b1);
        $display("test data sizes done");
    endtask
    task automatic test_addr_regs();
        wr(1'b1, 3'h2, SIZE_WORD, 32'h0000_8000);
        rd(3'h1, 3'h2, SIZE_LONG);
        check("a2 long", res_q.operand, 32'hFFFF_8000);
        rd(3'h1, 3'h2, SIZE_WORD);
        check("a2 word", res_q.operand, 32'h0000_8000);
        issue(6'h12, SIZE_LONG, 1'b0, 3'h7, 32'h0, 1'b1);
        check("jump space", res_q.program_space, 1'b1);
        check("jump address", res_q.address, 32'hFFFF_8000);
        wr(1'b1, 3'h3, SIZE_LONG, 32'h0000_0010);
        rd(3'h2, 3'h3, SIZE_LONG);
        check("data space", res_q.program_space, 1'b0);
        check("long word", {hi_word, lo_word}, 32'h4A4B_4849);
        $display("test addr regs done");
    endtask
    task automatic test_postinc();
        wr(1'b1, 3'h4, SIZE_LONG, 32'h0000_1000);
        rd(3'h3, 3'h4, SIZE_BYTE);
        check("postinc addr", res_q.address, 32'h0000_1000);
        rd(3'h3, 3'h4, SIZE_WORD);
        check("odd word", res_q.misaligned, 1'b1);
        rd(3'h3, 3'h4, SIZE_LONG);
        check("after word", res_q.address, 32'h0000_1003);
        rd(3'h1, 3'h4, SIZE_LONG);
        check("after long", res_q.operand, 32'h0000_1007);
        supervisor = 1'b1;
        wr(1'b1, 3'h7, SIZE_LONG, 32'h0000_2000);
        supervisor = 1'b0;
        wr(1'b1, 3'h7, SIZE_LONG, 32'h0000_3000);
        supervisor = 1'b1;
        rd(3'h3, 3'h7, SIZE_BYTE);
        rd(3'h1, 3'h7, SIZE_LONG);
        check("stack byte step", res_q.operand, 32'h0000_2002);
        supervisor = 1'b0;
        rd(3'h1, 3'h7, SIZE_LONG);
        check("user stack", res_q.operand, 32'h0000_3000);
        $display("test postinc done");
    endtask
    task automatic test_lengths();
        logic [8:0] exts [5] = '{9'o000, 9'o002, 9'o012, 9'o211, 9'o222};
        logic [2:0] n;
        foreach (exts[i]) begin
            issue(6'h10, SIZE_WORD, 1'b0, 3'h7, 32'h0, 1'b0, exts[i]);
            n = exts[i][8:6] + exts[i][5:3] + exts[i][2:0] + 3'h1;
            check("words", res_q.insn_words, n);
            check("valid", res_q.valid, 1'b1);
            check("first ext", res_q.first_ext, (exts[i][8:6] != 3'h0) ? 2'h0 :
                (exts[i][5:3] != 3'h0) ? 2'h1 : 2'h2);
            check("too long", res_q.illegal, n > 3'h5);
        end
        issue(6'h20, SIZE_WORD, 1'b0, 3'h7, 32'h0);
        check("mode four", res_q.illegal, 1'b1);
        $display("test lengths done");
    endtask
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        test_data_sizes();
        test_addr_regs();
        test_postinc();
        test_lengths();
        conclude();
    end
endmodule
